// [mfc_cfg.svh]
// offsets, field positions, reset values and timing counts of the field/cycle core
`ifndef MFC_CFG_SVH
`define MFC_CFG_SVH

`define MFC_CLK_MHZ 100
// register byte offsets
`define MFC_OFS_FIELD 8'h00
`define MFC_OFS_SAVED 8'h04
`define MFC_OFS_STATUS 8'h08
`define MFC_OFS_DATA 8'h0c
// field positions
`define MFC_FLD_LSB 0
`define MFC_SAVED_INT_LSB 2
`define MFC_ST_SRC_LSB 0
`define MFC_ST_TWO_WORD 2
`define MFC_ST_SUB_ARMED 3
`define MFC_ST_INT_ARMED 4
`define MFC_ST_WPHASE_LSB 5
// instruction register positions after the three-place shift
`define MFC_IR_CHANGE_BIT 6
`define MFC_IR_FIELD_HI 7
`define MFC_IR_FIELD_LO 8
`define MFC_IR_SHIFT 3
// reset value of every field register
`define MFC_FIELD_RST 2'h0
// times in ns and their cycle counts
`define MFC_STROBE_NS 200
`define MFC_READ_NS 600
`define MFC_INHIBIT_ENABLE_N_NS 800
`define MFC_TRIG_NS 50
`define MFC_WRITE_NS 600
`define MFC_STROBE_CYC ((`MFC_STROBE_NS * `MFC_CLK_MHZ) / 1000)
`define MFC_READ_CYC ((`MFC_READ_NS * `MFC_CLK_MHZ) / 1000)
`define MFC_INHIBIT_ENABLE_N_CYC ((`MFC_INHIBIT_ENABLE_N_NS * `MFC_CLK_MHZ + 999) / 1000)
`define MFC_TRIG_CYC ((`MFC_TRIG_NS * `MFC_CLK_MHZ) / 1000)
`define MFC_WRITE_CYC ((`MFC_WRITE_NS * `MFC_CLK_MHZ) / 1000)

`endif

// [mfc_pkg.sv]
// types of the memory field control and core cycle block
package mfc_pkg;

	typedef enum logic [1:0] {
		WR_IDLE,
		WR_TRIG,
		WR_DRIVE,
		WR_HOLD
	} mfc_wphase_t;

	// processor timing pulses, one clock each
	typedef struct packed {
		logic buffer_clear_pulse;
		logic timing_pulse_0;
		logic timing_pulse_1;
		logic timing_pulse_2;
		logic timing_pulse_3;
		logic timing_pulse_4;
		logic timing_pulse_5;
		logic basic_pulse_3;
		logic basic_pulse_5;
		logic execute_pulse_0;
	} mfc_pulses_t;

	// drive toward the core stack
	typedef struct packed {
		logic base_read_request_n;
		logic base_write_request_n;
		logic ext_read_request_n;
		logic ext_write_request_n;
		logic strobe;
		logic read_drive;
		logic inhibit_enable_n;
		logic write_trigger_oneshot;
		logic write_drive;
	} mfc_stack_ctl_t;

endpackage

// [mfc_core.sv]
// memory field selection, field return and core read/restore cycle sequencing
`timescale 1ns/1ps
`default_nettype none
`include "mfc_cfg.svh"

// Behaviour
// - extension read request at timing pulse 1
// - data register loaded at pulse 3 or 4
// - field 3 store keeps field 2 half
// - address latched after pulse 0, decoded
// - buffer cleared on clear pulse each cycle
// - 200 ns strobe, capture at trailing edge
// - 600 ns read interval with strobe
// - inhibit enable over 800 ns at pulse 5
// - short trigger, then 600 ns write
// - field bit 0 steers inhibit multiplexer
// - field register gives current field
// - jumps, interrupts, panel change current field
// - cycle steal uses requester's field
// - save old field on subroutine/interrupt
// - matching indirect jump restores saved field
// - three load/restore instructions affect return
// - single-word instruction uses current field
// - change bit clear keeps current field
// - change bit set: operand from IR bits 7,8
// - two-word flag at basic pulse 5
// - instruction register shifts three at BP3
// - source switches at EP0, reverts pulse 1
// - active-low select lines encode the field
// - fetch passes one half, restores whole
module mfc_core (
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// processor side
	input wire mfc_pkg::mfc_pulses_t pulses,
	input wire logic mem_cycle,
	input wire logic store_cycle,
	input wire logic [11:0] store_data,
	input wire logic [11:0] addr_in,
	input wire logic [11:0] instr_in,
	input wire logic first_basic_phase,
	input wire logic second_basic_phase,
	input wire logic execute_phase,
	input wire logic two_word_decode,
	input wire logic mem_ref_instr,
	input wire logic jump_instr,
	input wire logic subroutine_jump_instr,
	input wire logic load_pair_instr,
	input wire logic load_regs_instr,
	input wire logic restore_status_instr,
	input wire logic interrupt_take,
	input wire logic [1:0] interrupt_field,
	input wire logic sub_return_match,
	input wire logic int_return_match,
	input wire logic steal_active,
	input wire logic [1:0] steal_field,
	// core stack side
	input wire logic [23:0] sense_data,
	output mfc_pkg::mfc_stack_ctl_t stack_ctl,
	output logic field_select_lo_n,
	output logic field_select_hi_n,
	output logic [11:0] addr_q,
	output logic [23:0] write_word_q,
	output logic [11:0] mdr_q,
	output logic two_word_flag_n,
	output logic field_from_instruction
);

	localparam logic [6:0] STROBE_CYC = 7'(`MFC_STROBE_CYC);
	localparam logic [6:0] READ_CYC = 7'(`MFC_READ_CYC);
	localparam logic [6:0] INHIBIT_ENABLE_N_CYC = 7'(`MFC_INHIBIT_ENABLE_N_CYC);
	localparam logic [6:0] TRIG_CYC = 7'(`MFC_TRIG_CYC);
	localparam logic [6:0] WRITE_CYC = 7'(`MFC_WRITE_CYC);

	logic [1:0] cur_field_q;
	logic [1:0] sub_field_q;
	logic [1:0] int_field_q;
	logic sub_armed_q;
	logic int_armed_q;
	logic [11:0] ir_q;
	logic two_word_q;
	logic from_instr_q;
	logic [1:0] eff_field;
	logic ext_sel;
	logic odd_sel;
	logic [23:0] mbr_q;
	logic rd_go;
	logic wr_go;
	logic [6:0] strobe_cnt_q;
	logic [6:0] read_cnt_q;
	logic [6:0] inhibit_enable_n_cnt_q;
	logic [6:0] wr_cnt_q;
	mfc_pkg::mfc_wphase_t wphase_q;
	logic change_ep0;
	logic [1:0] ir_field;

	// ----------------------------------------------------------------
	// field selection
	// ----------------------------------------------------------------
	assign ir_field = {ir_q[`MFC_IR_FIELD_HI], ir_q[`MFC_IR_FIELD_LO]};
	// a steal always wins: the requester owns the whole cycle
	always_comb begin
		if (steal_active) begin
			eff_field = steal_field;
		end else if (from_instr_q) begin
			eff_field = ir_field;
		end else begin
			eff_field = cur_field_q;
		end
	end
	assign field_select_lo_n = ~eff_field[1];
	assign field_select_hi_n = ~eff_field[0];
	assign ext_sel = eff_field[1];
	assign odd_sel = eff_field[0];
	assign field_from_instruction = from_instr_q;
	assign two_word_flag_n = ~two_word_q;
	assign change_ep0 = pulses.execute_pulse_0 & two_word_q
		& ir_q[`MFC_IR_CHANGE_BIT];

	// ----------------------------------------------------------------
	// instruction register and two-word flag
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ir_q <= 12'h000;
		end else if (pulses.basic_pulse_3 && first_basic_phase) begin
			ir_q <= instr_in;
		end else if (pulses.basic_pulse_3 && second_basic_phase
			&& two_word_q) begin
			ir_q <= ir_q << `MFC_IR_SHIFT;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			two_word_q <= 1'b0;
		end else if (pulses.basic_pulse_5 && first_basic_phase) begin
			two_word_q <= two_word_decode;
		end else if (pulses.timing_pulse_1 && !execute_phase
			&& !second_basic_phase && !first_basic_phase) begin
			two_word_q <= 1'b0;
		end
	end

	// operand field source: set at EP0, back to current at pulse 1
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			from_instr_q <= 1'b0;
		end else if (change_ep0 && mem_ref_instr && !jump_instr
			&& !subroutine_jump_instr) begin
			from_instr_q <= 1'b1;
		end else if (pulses.timing_pulse_1 && !execute_phase) begin
			from_instr_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// current field and automatic return
	// ----------------------------------------------------------------
	logic pan_wr;
	logic [1:0] pan_val;

	// hardware field changes win over a panel load in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur_field_q <= `MFC_FIELD_RST;
		end else if (interrupt_take) begin
			cur_field_q <= interrupt_field;
		end else if (change_ep0 && (jump_instr
			|| subroutine_jump_instr)) begin
			cur_field_q <= ir_field;
		end else if (sub_return_match && sub_armed_q) begin
			cur_field_q <= sub_field_q;
		end else if (int_return_match && int_armed_q) begin
			cur_field_q <= int_field_q;
		end else if (pan_wr) begin
			cur_field_q <= pan_val;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sub_field_q <= `MFC_FIELD_RST;
			sub_armed_q <= 1'b0;
		end else if (change_ep0 && subroutine_jump_instr) begin
			sub_field_q <= cur_field_q;
			sub_armed_q <= 1'b1;
		end else if (sub_return_match && sub_armed_q) begin
			sub_armed_q <= 1'b0;
		end else if (pulses.execute_pulse_0 && (load_pair_instr
			|| load_regs_instr)) begin
			sub_armed_q <= 1'b0;
		end
	end

	// restore-status or load-regs at EP0 ends that return without reinstating the interrupted field
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_field_q <= `MFC_FIELD_RST;
			int_armed_q <= 1'b0;
		end else if (interrupt_take) begin
			int_field_q <= cur_field_q;
			int_armed_q <= 1'b1;
		end else if (int_return_match && int_armed_q) begin
			int_armed_q <= 1'b0;
		end else if (pulses.execute_pulse_0 && (restore_status_instr
			|| load_regs_instr)) begin
			int_armed_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// address, buffer and data registers
	// ----------------------------------------------------------------
	// pulse 0 is one clock, so its trailing edge is the clock that ends it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_q <= 12'h000;
		end else if (pulses.timing_pulse_0) begin
			addr_q <= addr_in;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mbr_q <= 24'h000000;
		end else if (pulses.buffer_clear_pulse) begin
			mbr_q <= 24'h000000;
		end else if (strobe_cnt_q == 7'h01) begin
			mbr_q <= sense_data;
		end
	end

	// store: bus word; fetch: the half picked by field bit 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mdr_q <= 12'h000;
		end else if (mem_cycle && (pulses.timing_pulse_3
			|| pulses.timing_pulse_4)) begin
			if (store_cycle) begin
				mdr_q <= store_data;
			end else begin
				mdr_q <= odd_sel ? mbr_q[23:12] : mbr_q[11:0];
			end
		end
	end

	// the other half of the double word is rewritten as it was read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			write_word_q <= 24'h000000;
		end else if (wr_go) begin
			if (odd_sel) begin
				write_word_q <= {mdr_q, mbr_q[11:0]};
			end else begin
				write_word_q <= {mbr_q[23:12], mdr_q};
			end
		end
	end

	// ----------------------------------------------------------------
	// core cycle timing
	// ----------------------------------------------------------------
	// extension fields start one pulse earlier than the base stack
	assign rd_go = mem_cycle && (ext_sel ? pulses.timing_pulse_1
		: pulses.timing_pulse_2);
	assign wr_go = mem_cycle && pulses.timing_pulse_5;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strobe_cnt_q <= 7'h00;
			read_cnt_q <= 7'h00;
		end else if (rd_go) begin
			strobe_cnt_q <= STROBE_CYC;
			read_cnt_q <= READ_CYC;
		end else begin
			if (strobe_cnt_q != 7'h00) begin
				strobe_cnt_q <= strobe_cnt_q - 7'h01;
			end
			if (read_cnt_q != 7'h00) begin
				read_cnt_q <= read_cnt_q - 7'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			inhibit_enable_n_cnt_q <= 7'h00;
		end else if (wr_go) begin
			inhibit_enable_n_cnt_q <= INHIBIT_ENABLE_N_CYC;
		end else if (inhibit_enable_n_cnt_q != 7'h00) begin
			inhibit_enable_n_cnt_q <= inhibit_enable_n_cnt_q - 7'h01;
		end
	end

	// the write drive begins only when the trigger pulse has ended
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wphase_q <= mfc_pkg::WR_IDLE;
			wr_cnt_q <= 7'h00;
		end else begin
			case (wphase_q)
			mfc_pkg::WR_IDLE: begin
				if (wr_go) begin
					wphase_q <= mfc_pkg::WR_TRIG;
					wr_cnt_q <= TRIG_CYC;
				end
			end
			mfc_pkg::WR_TRIG: begin
				if (wr_cnt_q == 7'h01) begin
					wphase_q <= mfc_pkg::WR_DRIVE;
					wr_cnt_q <= WRITE_CYC;
				end else begin
					wr_cnt_q <= wr_cnt_q - 7'h01;
				end
			end
			mfc_pkg::WR_DRIVE: begin
				if (wr_cnt_q == 7'h01) begin
					wphase_q <= mfc_pkg::WR_HOLD;
					wr_cnt_q <= 7'h00;
				end else begin
					wr_cnt_q <= wr_cnt_q - 7'h01;
				end
			end
			mfc_pkg::WR_HOLD: begin
				if (inhibit_enable_n_cnt_q == 7'h00) begin
					wphase_q <= mfc_pkg::WR_IDLE;
				end
			end
			default: begin
				wphase_q <= mfc_pkg::WR_IDLE;
				wr_cnt_q <= 7'h00;
			end
			endcase
		end
	end

	always_comb begin
		stack_ctl.base_read_request_n = ~(rd_go & ~ext_sel);
		stack_ctl.ext_read_request_n = ~(rd_go & ext_sel);
		stack_ctl.base_write_request_n = ~(wr_go & ~ext_sel);
		stack_ctl.ext_write_request_n = ~(wr_go & ext_sel);
		stack_ctl.strobe = strobe_cnt_q != 7'h00;
		stack_ctl.read_drive = read_cnt_q != 7'h00;
		stack_ctl.inhibit_enable_n = inhibit_enable_n_cnt_q == 7'h00;
		stack_ctl.write_trigger_oneshot = wphase_q == mfc_pkg::WR_TRIG;
		stack_ctl.write_drive = wphase_q == mfc_pkg::WR_DRIVE;
	end

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	logic aw_got_q;
	logic w_got_q;
	logic [7:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic [31:0] rd_val;
	logic rd_ok;

	assign s_axi_awready = ~aw_got_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got_q & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign pan_wr = aw_got_q && w_got_q && ws_q[0]
		&& aw_q == `MFC_OFS_FIELD;
	assign pan_val = wd_q[`MFC_FLD_LSB +: 2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_q <= 8'h00;
			wd_q <= 32'h00000000;
			ws_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				aw_q <= {s_axi_awaddr[7:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (aw_got_q && w_got_q) begin
				aw_got_q <= 1'b0;
				w_got_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_q == `MFC_OFS_FIELD) ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_val = 32'h00000000;
		rd_ok = 1'b1;
		case ({s_axi_araddr[7:2], 2'h0})
		`MFC_OFS_FIELD: rd_val[`MFC_FLD_LSB +: 2] = cur_field_q;
		`MFC_OFS_SAVED: begin
			rd_val[1:0] = sub_field_q;
			rd_val[`MFC_SAVED_INT_LSB +: 2] = int_field_q;
		end
		`MFC_OFS_STATUS: begin
			rd_val[`MFC_ST_SRC_LSB +: 2] = eff_field;
			rd_val[`MFC_ST_TWO_WORD] = two_word_q;
			rd_val[`MFC_ST_SUB_ARMED] = sub_armed_q;
			rd_val[`MFC_ST_INT_ARMED] = int_armed_q;
			rd_val[`MFC_ST_WPHASE_LSB +: 2] = wphase_q;
		end
		`MFC_OFS_DATA: rd_val = {8'h00, mbr_q};
		default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// [mfc_core_monitor.sv]
// assertion checker of the field/cycle core ports
`timescale 1ns/1ps
`default_nettype none
module mfc_core_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire mfc_pkg::mfc_pulses_t pulses,
	input wire logic mem_cycle,
	input wire logic store_cycle,
	input wire logic [11:0] store_data,
	input wire logic [11:0] addr_in,
	input wire logic first_basic_phase,
	input wire logic two_word_decode,
	input wire logic steal_active,
	input wire logic [1:0] steal_field,
	input wire mfc_pkg::mfc_stack_ctl_t stack_ctl,
	input wire logic field_select_lo_n,
	input wire logic field_select_hi_n,
	input wire logic [11:0] addr_q,
	input wire logic [23:0] write_word_q,
	input wire logic [11:0] mdr_q,
	input wire logic two_word_flag_n
);
	// ----
	// helpers
	// ----
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wire logic rd = !stack_ctl.base_read_request_n
		|| !stack_ctl.ext_read_request_n;
	wire logic wr = !stack_ctl.base_write_request_n
		|| !stack_ctl.ext_write_request_n;
	sequence s_strobe;
		stack_ctl.strobe [*8] ##12 stack_ctl.strobe ##1 !stack_ctl.strobe;
	endsequence
	sequence s_trig;
		stack_ctl.write_trigger_oneshot [*5]
			##1 (!stack_ctl.write_trigger_oneshot && stack_ctl.write_drive);
	endsequence
	// ----
	// properties
	// ----
	property p_ext_rd;
		!stack_ctl.ext_read_request_n
			== (pulses.timing_pulse_1 && mem_cycle && !field_select_lo_n);
	endproperty
	a_ext_rd: assert property (p_ext_rd) else $error("bad ext read");
	property p_base_rd;
		!stack_ctl.base_read_request_n
			== (pulses.timing_pulse_2 && mem_cycle && field_select_lo_n);
	endproperty
	a_base_rd: assert property (p_base_rd) else $error("bad read");
	property p_ext_wr;
		!stack_ctl.ext_write_request_n
			== (pulses.timing_pulse_5 && mem_cycle && !field_select_lo_n);
	endproperty
	a_ext_wr: assert property (p_ext_wr) else $error("bad ext write");
	property p_strobe;
		rd |=> s_strobe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("bad strobe");
	property p_read;
		rd |=> ##59 stack_ctl.read_drive ##1 !stack_ctl.read_drive;
	endproperty
	a_read: assert property (p_read) else $error("bad read drive");
	property p_inhibit_enable_n;
		wr |=> !stack_ctl.inhibit_enable_n [*8] ##72
			!stack_ctl.inhibit_enable_n ##1 stack_ctl.inhibit_enable_n;
	endproperty
	a_inhibit_enable_n: assert property (p_inhibit_enable_n) else $error("bad inhibit");
	property p_write;
		wr |=> s_trig ##59 stack_ctl.write_drive ##1 !stack_ctl.write_drive;
	endproperty
	a_write: assert property (p_write) else $error("bad write");
	property p_mux;
		wr |=> ($past(field_select_hi_n) ? write_word_q[11:0]
			: write_word_q[23:12]) == $past(mdr_q);
	endproperty
	a_mux: assert property (p_mux) else $error("bad half");
	property p_addr;
		pulses.timing_pulse_0 |=> addr_q == $past(addr_in);
	endproperty
	a_addr: assert property (p_addr) else $error("bad address");
	property p_store;
		pulses.timing_pulse_3 && mem_cycle && store_cycle
			|=> mdr_q == $past(store_data);
	endproperty
	a_store: assert property (p_store) else $error("bad data load");
	property p_tw;
		pulses.basic_pulse_5 && first_basic_phase && two_word_decode
			|=> !two_word_flag_n;
	endproperty
	a_tw: assert property (p_tw) else $error("no two-word flag");
	property p_steal;
		steal_active
			|-> {field_select_lo_n, field_select_hi_n} == ~steal_field;
	endproperty
	a_steal: assert property (p_steal) else $error("bad steal field");
endmodule
bind mfc_core mfc_core_monitor u_mfc_core_monitor (.*);
`default_nettype wire

// [mfc_stack_model.sv]
// behavioural core stack: base and extension double-word banks
`timescale 1ns/1ps
`default_nettype none
module mfc_stack_model (
	input wire logic aclk,
	input wire mfc_pkg::mfc_stack_ctl_t stack_ctl,
	input wire logic [11:0] addr_q,
	input wire logic [23:0] write_word_q,
	output logic [23:0] sense_data
);
	// ----
	// storage
	// ----
	logic [23:0] mem [2][4096];
	logic bank_q, rd_q, wd_q;
	initial begin
		for (int a = 0; a < 4096; a++) begin
			mem[0][a] = {12'(a) ^ 12'ha5a, 12'(a * 3)};
			mem[1][a] = {12'(a) ^ 12'h3c3, 12'(a * 5)};
		end
		sense_data = 24'h000000;
		bank_q = 1'h0;
		rd_q = 1'h0;
		wd_q = 1'h0;
	end
	always @(posedge aclk) begin
		rd_q <= stack_ctl.read_drive;
		wd_q <= stack_ctl.write_drive;
		if (!stack_ctl.base_read_request_n)
			bank_q <= 1'h0;
		if (!stack_ctl.ext_read_request_n)
			bank_q <= 1'h1;
		// amps are only valid inside the strobe, so show junk elsewhere
		sense_data <= stack_ctl.strobe ? mem[bank_q][addr_q] : ~sense_data;
		// destructive read: the word is gone until written back
		if (rd_q && !stack_ctl.read_drive)
			mem[bank_q][addr_q] <= 24'h000000;
		if (!wd_q && stack_ctl.write_drive)
			mem[bank_q][addr_q] <= write_word_q;
	end
endmodule
`default_nettype wire

// [mfc_core_tb.sv]
// self-checking bench of the field/cycle core
`timescale 1ns/1ps
`default_nettype none
module mfc_core_tb;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, mc, st, fb, sb, ex, twd;
	logic itk, srm, irm, sta, flo_n, fhi_n, twf_n, ffi;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, ifld, sfld, g;
	logic [11:0] sd, ai, ir, aq, mq, a;
	logic [23:0] sense, ww;
	logic [5:0] dec;
	logic [23:0] rm [2][4096];
	mfc_pkg::mfc_pulses_t pulses;
	mfc_pkg::mfc_stack_ctl_t sc;
	int num_errors, n_compared, cf, ss, is;
	int fs[5] = '{0, 1, 2, 3, 2};
	mfc_core u_mfc_core (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pulses(pulses), .mem_cycle(mc),
		.store_cycle(st), .store_data(sd), .addr_in(ai), .instr_in(ir),
		.first_basic_phase(fb), .second_basic_phase(sb),
		.execute_phase(ex), .two_word_decode(twd),
		.mem_ref_instr(dec[0]), .jump_instr(dec[1]),
		.subroutine_jump_instr(dec[2]), .load_pair_instr(dec[3]),
		.load_regs_instr(dec[4]), .restore_status_instr(dec[5]),
		.interrupt_take(itk), .interrupt_field(ifld),
		.sub_return_match(srm), .int_return_match(irm),
		.steal_active(sta), .steal_field(sfld), .sense_data(sense),
		.stack_ctl(sc), .field_select_lo_n(flo_n),
		.field_select_hi_n(fhi_n), .addr_q(aq), .write_word_q(ww),
		.mdr_q(mq), .two_word_flag_n(twf_n), .field_from_instruction(ffi)
	);
	mfc_stack_model u_mfc_stack_model (
		.aclk(aclk), .stack_ctl(sc), .addr_q(aq), .write_word_q(ww),
		.sense_data(sense)
	);
	// ----
	// helpers
	// ----
	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	task automatic finish_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic pu(input int i, g);
		pulses <= mfc_pkg::mfc_pulses_t'(10'h001 << i);
		@(posedge aclk);
		pulses <= '0;
		repeat (g) @(posedge aclk);
	endtask
	// handshakes are sampled at the negedge, which equals the next edge
	task automatic aw(input logic [7:0] ad, input logic [31:0] d, e);
		logic ha, hw, hb;
		logic [1:0] q;
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		hb = 1'h0;
		while (!hb) begin
			@(negedge aclk);
			ha = awready;
			hw = wready;
			hb = bvalid;
			q = bresp;
			@(posedge aclk);
			if (ha)
				awvalid <= 1'h0;
			if (hw)
				wvalid <= 1'h0;
		end
		bready <= 1'h0;
		@(posedge aclk);
		chk("bresp", q, e);
	endtask
	task automatic ar(input logic [7:0] ad, input logic [31:0] e, r);
		logic h, hv;
		logic [31:0] d;
		logic [1:0] q;
		araddr <= ad;
		arvalid <= 1'h1;
		rready <= 1'h1;
		hv = 1'h0;
		while (!hv) begin
			@(negedge aclk);
			h = arready;
			hv = rvalid;
			d = rdata;
			q = rresp;
			@(posedge aclk);
			if (h)
				arvalid <= 1'h0;
		end
		rready <= 1'h0;
		@(posedge aclk);
		chk("rdata", d, e);
		chk("rresp", q, r);
	endtask
	task automatic fl(input logic [1:0] f);
		@(negedge aclk);
		chk("fsel", {flo_n, fhi_n}, 2'(~f));
		@(posedge aclk);
	endtask
	task automatic cyc(input logic s, input logic [11:0] ad, d);
		logic [23:0] m, w;
		logic [11:0] h;
		m = rm[cf[1]][ad];
		h = s ? d : (cf[0] ? m[23:12] : m[11:0]);
		w = cf[0] ? {h, m[11:0]} : {m[23:12], h};
		mc <= 1'h1;
		st <= s;
		sd <= d;
		ai <= ad;
		pu(9, 1);
		ar(8'h0c, 0, 0);
		pu(8, 1);
		pu(7, 1);
		pu(6, 25);
		ar(8'h0c, m, 0);
		pu(5, 40);
		chk("mdr", mq, h);
		pu(3, 1);
		chk("word", ww, w);
		mc <= 1'h0;
		repeat (85) @(posedge aclk);
		rm[cf[1]][ad] = w;
	endtask
	task automatic tw(input logic [1:0] f, input logic [5:0] k);
		ir <= {6'h00, f[0], f[1], 1'h1, 3'h0};
		fb <= 1'h1;
		twd <= 1'h1;
		pu(2, 1);
		pu(1, 1);
		chk("twflag", twf_n, 0);
		fb <= 1'h0;
		twd <= 1'h0;
		sb <= 1'h1;
		pu(2, 1);
		sb <= 1'h0;
		ex <= 1'h1;
		dec <= k;
		pu(0, 1);
		dec <= 6'h00;
		ex <= 1'h0;
	endtask
	task automatic ret(input logic i);
		srm <= !i;
		irm <= i;
		@(posedge aclk);
		srm <= 1'h0;
		irm <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic irq(input logic [1:0] f);
		itk <= 1'h1;
		ifld <= f;
		@(posedge aclk);
		itk <= 1'h0;
		@(posedge aclk);
	endtask
	// ----
	// tests
	// ----
	initial begin
		repeat (12000) @(posedge aclk);
		num_errors++;
		finish_test();
	end
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
		{mc, st, fb, sb, ex, twd, itk, srm, irm, sta} <= 10'h000;
		{awaddr, araddr, wdata, ifld, sfld} <= 52'h0;
		{sd, ai, ir, dec} <= 42'h0;
		pulses <= '0;
		for (int i = 0; i < 4096; i++) begin
			rm[0][i] = {12'(i) ^ 12'ha5a, 12'(i * 3)};
			rm[1][i] = {12'(i) ^ 12'h3c3, 12'(i * 5)};
		end
		void'($urandom(39556));
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		ar(8'h00, 0, 0);
		ar(8'h04, 0, 0);
		ar(8'h10, 0, 2);
		aw(8'h04, 1, 2);
		a = 12'($urandom);
		for (int i = 0; i < 5; i++) begin
			cf = fs[i];
			aw(8'h00, cf, 0);
			ar(8'h00, cf, 0);
			fl(2'(cf));
			cyc(1'h1, a, 12'($urandom));
			cyc(1'h0, a, 12'h000);
		end
		g = 2'($urandom);
		tw(g, 6'h01);
		chk("ffi", ffi, 1);
		fl(g);
		pu(7, 1);
		chk("ffi", ffi, 0);
		fl(2'(cf));
		// single-word reference: no two-word flag, so no switch
		ex <= 1'h1;
		dec <= 6'h01;
		pu(0, 1);
		chk("ffi", ffi, 0);
		dec <= 6'h00;
		ex <= 1'h0;
		pu(7, 1);
		cf = g ^ 2'h1;
		tw(2'(cf), 6'h02);
		pu(7, 1);
		ar(8'h00, cf, 0);
		for (int k = 0; k < 2; k++) begin
			ss = cf;
			cf = cf ^ 2;
			tw(2'(cf), 6'h04);
			pu(7, 1);
			ar(8'h04, is * 4 + ss, 0);
			if (k == 1) begin
				ex <= 1'h1;
				dec <= 6'h18;
				pu(0, 1);
				dec <= 6'h00;
				ex <= 1'h0;
				@(posedge aclk);
			end else
				cf = ss;
			ret(1'h0);
			ar(8'h00, cf, 0);
		end
		for (int k = 0; k < 2; k++) begin
			is = cf;
			cf = cf ^ 1;
			irq(2'(cf));
			ar(8'h04, is * 4 + ss, 0);
			if (k == 1) begin
				ex <= 1'h1;
				dec <= 6'h20;
				pu(0, 1);
				dec <= 6'h00;
				ex <= 1'h0;
				@(posedge aclk);
			end else
				cf = is;
			ret(1'h1);
			ar(8'h00, cf, 0);
		end
		g = 2'($urandom);
		sta <= 1'h1;
		sfld <= g;
		fl(g);
		sta <= 1'h0;
		@(posedge aclk);
		finish_test();
	end
endmodule
`default_nettype wire
